// >>> core/logic_tile.sv
// Four-slice programmable logic tile: lookup tables, ripple carry,
// distributed RAM/ROM, wide-function combining and slice registers.
// Assumes routing inputs synchronous to CLOCK_IN and a plain register port.
`timescale 1ns/10ps
module logic_tile #(
   parameter bit MEM_CAPABLE = 1'b1
) (
   input wire logic CLOCK_IN,
   input wire logic RST_IN,
   input wire logic CE_IN,
   input wire logic [tile_pkg::ADDR_W-1:0] REG_ADDR_IN,
   input wire logic [tile_pkg::DATA_W-1:0] REG_WDATA_IN,
   input wire logic REG_WR_IN,
   input wire logic REG_RD_IN,
   output logic [tile_pkg::DATA_W-1:0] REG_RDATA_OUT,
   input wire tile_pkg::reg_slice_in_t [2:0] REG_SLICE_IN,
   input wire tile_pkg::lut_slice_in_t LUT_SLICE_IN,
   input wire logic CARRY_IN,
   output tile_pkg::reg_slice_out_t [2:0] REG_SLICE_OUT,
   output tile_pkg::lut_slice_out_t LUT_SLICE_OUT,
   output logic CARRY_OUT
);

   // Whole tile state
   typedef struct packed {
      logic [7:0][15:0] lut;
      tile_pkg::slice_mode_t [3:0] mode;
      tile_pkg::reg_cfg_t [2:0] cfg;
      logic [2:0][1:0] q;
      logic [2:0] clk_prev;
      logic [31:0] rdata;
   } state_t;

   localparam state_t ST_RESET = '{
      lut: {8{tile_pkg::LUT_RESET}},
      mode: '{default: tile_pkg::MODE_RESET},
      cfg: {3{tile_pkg::CFG_RESET}},
      q: '0,
      clk_prev: '0,
      rdata: '0
   };

   state_t st_q;
   state_t st_d;

   logic [3:0][3:0] in0;
   logic [3:0][3:0] in1;
   logic [3:0] m0;
   logic [3:0] m1;
   logic [7:0] f;
   logic [3:0] c;
   logic [3:0] ofx0;
   logic [3:0] ofx1;
   logic [2:0] evt;
   logic [2:0] rise;
   logic [2:0] fall;

   // Address decode shared by read and write paths
   function automatic logic is_lut_addr(input logic [3:0] addr);
      return addr[3] == 1'b0;
   endfunction

   // Drops modes a slice or variant does not offer
   function automatic tile_pkg::slice_mode_t legal_mode(input int s,
                                                        input tile_pkg::slice_mode_t m);
      if (s == 3 && (m == tile_pkg::MODE_RIPPLE || m == tile_pkg::MODE_RAM))
      begin
         return tile_pkg::MODE_LOGIC;
      end
      if (!MEM_CAPABLE && m == tile_pkg::MODE_RAM)
      begin
         return tile_pkg::MODE_LOGIC;
      end
      return m;
   endfunction

   function automatic logic maj(input logic a, input logic b, input logic ci);
      return (a & b) | (a & ci) | (b & ci);
   endfunction

   // Gather routing inputs of the registered slices
   generate
      for (genvar s = 0; s < 3; s++)
      begin : g_in
         assign in0[s] = REG_SLICE_IN[s].lut0;
         assign in1[s] = REG_SLICE_IN[s].lut1;
         assign m0[s] = REG_SLICE_IN[s].m0;
         assign m1[s] = REG_SLICE_IN[s].m1;
      end
   endgenerate

   // Slice 3 routing inputs, no carry
   assign in0[3] = LUT_SLICE_IN.lut0;
   assign in1[3] = LUT_SLICE_IN.lut1;
   assign m0[3] = LUT_SLICE_IN.m0;
   assign m1[3] = LUT_SLICE_IN.m1;
   assign c[0] = CARRY_IN;

   // Table lookup, ripple adder and five-input mux per slice
   generate
      for (genvar s = 0; s < 4; s++)
      begin : g_slice
         logic cmid;
         logic ripple;
         assign ripple = (st_q.mode[s] == tile_pkg::MODE_RIPPLE);
         assign cmid = maj(in0[s][0], in0[s][1], c[s]);
         assign f[2*s] = ripple ? in0[s][0] ^ in0[s][1] ^ c[s]
                                : st_q.lut[2*s][in0[s]];
         assign f[2*s+1] = ripple ? in1[s][0] ^ in1[s][1] ^ cmid
                                  : st_q.lut[2*s+1][in1[s]];
         assign ofx0[s] = m0[s] ? f[2*s+1] : f[2*s];
         if (s < 3)
         begin : g_carry
            // Non-ripple slices pass the chain straight through
            assign c[s+1] = ripple ? maj(in1[s][0], in1[s][1], cmid) : c[s];
         end
      end
   endgenerate

   // Six-, seven- and eight-input combining; slice 3 takes a far seven-input result
   assign ofx1[0] = m1[0] ? ofx0[1] : ofx0[0];
   assign ofx1[2] = m1[2] ? ofx0[3] : ofx0[2];
   assign ofx1[1] = m1[1] ? ofx1[2] : ofx1[0];
   assign ofx1[3] = m1[3] ? in1[3][3] : ofx1[1];
   assign CARRY_OUT = c[3];

   // Clock events seen on the routed clocks
   generate
      for (genvar s = 0; s < 3; s++)
      begin : g_evt
         tile_pkg::reg_cfg_t cfg;
         logic rclk;
         assign cfg = st_q.cfg[s];
         assign rclk = REG_SLICE_IN[s].clk;
         assign rise[s] = rclk & ~st_q.clk_prev[s];
         assign fall[s] = ~rclk & st_q.clk_prev[s];
         // Clock select, then edge or transparent level
         assign evt[s] = cfg.free_clk ? 1'b1 :
                         cfg.edge_trig ? (cfg.pos ? rise[s] : fall[s]) :
                         (cfg.pos ? rclk : ~rclk);
      end
   endgenerate

   // Next state: register port, slice registers, RAM writes
   always_comb
   begin
      st_d = st_q;
      st_d.rdata = '0;
      if (REG_RD_IN)
      begin
         if (is_lut_addr(REG_ADDR_IN))
         begin
            st_d.rdata = {16'h0000, st_q.lut[REG_ADDR_IN[2:0]]};
         end
         else if (REG_ADDR_IN == tile_pkg::ADDR_MODE)
         begin
            st_d.rdata = {24'h000000, st_q.mode};
         end
         else if (REG_ADDR_IN == tile_pkg::ADDR_REGCFG)
         begin
            st_d.rdata = {8'h00, 2'b00, st_q.cfg[2], 2'b00, st_q.cfg[1], 2'b00, st_q.cfg[0]};
         end
         else if (REG_ADDR_IN == tile_pkg::ADDR_STATUS)
         begin
            st_d.rdata = {23'h000000, MEM_CAPABLE, 2'b00, st_q.q};
         end
      end
      if (REG_WR_IN)
      begin
         if (is_lut_addr(REG_ADDR_IN))
         begin
            st_d.lut[REG_ADDR_IN[2:0]] = REG_WDATA_IN[15:0];
         end
         else if (REG_ADDR_IN == tile_pkg::ADDR_MODE)
         begin
            for (int s = 0; s < 4; s++)
            begin
               st_d.mode[s] = legal_mode(s, tile_pkg::slice_mode_t'(
                  REG_WDATA_IN[tile_pkg::MODE_STRIDE*s +: tile_pkg::MODE_STRIDE]));
            end
         end
         else if (REG_ADDR_IN == tile_pkg::ADDR_REGCFG)
         begin
            for (int s = 0; s < 3; s++)
            begin
               st_d.cfg[s] = tile_pkg::reg_cfg_t'(
                  REG_WDATA_IN[tile_pkg::CFG_STRIDE*s +: tile_pkg::CFG_W]);
            end
         end
      end
      for (int s = 0; s < 3; s++)
      begin
         st_d.clk_prev[s] = REG_SLICE_IN[s].clk;
         if (st_q.mode[s] == tile_pkg::MODE_RAM)
         begin
            // Set/reset line acts as chip-select; fabric write beats port write
            if (REG_SLICE_IN[s].ce && REG_SLICE_IN[s].lsr == st_q.cfg[s].cs_pol)
            begin
               st_d.lut[2*s][in0[s]] = m0[s];
               st_d.lut[2*s+1][in0[s]] = m1[s];
            end
         end
         else if (REG_SLICE_IN[s].lsr && (!st_q.cfg[s].sync_lsr || evt[s]))
         begin
            st_d.q[s] = {2{st_q.cfg[s].set_val}};
         end
         else if (evt[s] && REG_SLICE_IN[s].ce)
         begin
            st_d.q[s] = {f[2*s+1], f[2*s]};
         end
      end
   end

   // State register with freeze
   always_ff @(posedge CLOCK_IN or posedge RST_IN)
   begin
      if (RST_IN)
      begin
         st_q <= ST_RESET;
      end
      else if (CE_IN)
      begin
         st_q <= st_d;
      end
   end

   // Routing outputs
   generate
      for (genvar s = 0; s < 3; s++)
      begin : g_out
         assign REG_SLICE_OUT[s] = {f[2*s], f[2*s+1], st_q.q[s][0], st_q.q[s][1],
                                    ofx0[s], ofx1[s]};
      end
   endgenerate
   assign LUT_SLICE_OUT = {f[6], f[7], ofx0[3], ofx1[3]};
   assign REG_RDATA_OUT = st_q.rdata;

   // Checks
   default clocking cb @(posedge CLOCK_IN);
   endclocking
   default disable iff (RST_IN);

   property p_lut5;
      REG_SLICE_OUT[0].ofx0 == (m0[0] ? REG_SLICE_OUT[0].f1 : REG_SLICE_OUT[0].f0);
   endproperty
   a_lut5: assert property (p_lut5) else $error("five-input mux wrong");

   property p_lut7;
      (!m1[0] && !m1[1]) |-> REG_SLICE_OUT[1].ofx1 == REG_SLICE_OUT[0].ofx0;
   endproperty
   a_lut7: assert property (p_lut7) else $error("seven-input path wrong");

   property p_no_ram;
      !MEM_CAPABLE |-> (st_q.mode[0] != tile_pkg::MODE_RAM && st_q.mode[1] !=
         tile_pkg::MODE_RAM && st_q.mode[2] != tile_pkg::MODE_RAM);
   endproperty
   a_no_ram: assert property (p_no_ram) else $error("RAM mode in ROM-only tile");

   property p_slice3;
      st_q.mode[3] == tile_pkg::MODE_LOGIC || st_q.mode[3] == tile_pkg::MODE_ROM;
   endproperty
   a_slice3: assert property (p_slice3) else $error("slice 3 in illegal mode");

   property p_rise;
      (CE_IN && st_q.cfg[0].edge_trig && st_q.cfg[0].pos && !st_q.cfg[0].free_clk &&
       rise[0] && REG_SLICE_IN[0].ce && !REG_SLICE_IN[0].lsr &&
       st_q.mode[0] != tile_pkg::MODE_RAM) |=> st_q.q[0][0] == $past(f[0]);
   endproperty
   a_rise: assert property (p_rise) else $error("rising edge load missed");

   property p_latch_hold;
      (CE_IN && !st_q.cfg[2].edge_trig && !st_q.cfg[2].free_clk &&
       REG_SLICE_IN[2].clk != st_q.cfg[2].pos && !REG_SLICE_IN[2].lsr) |=> $stable(st_q.q[2]);
   endproperty
   a_latch_hold: assert property (p_latch_hold) else $error("closed latch changed");

   property p_async;
      (CE_IN && !st_q.cfg[0].sync_lsr && REG_SLICE_IN[0].lsr &&
       st_q.mode[0] != tile_pkg::MODE_RAM) |=> st_q.q[0] == {2{$past(st_q.cfg[0].set_val)}};
   endproperty
   a_async: assert property (p_async) else $error("async set/reset missed");

   property p_sync_hold;
      (CE_IN && st_q.cfg[0].sync_lsr && st_q.cfg[0].edge_trig && !st_q.cfg[0].free_clk &&
       REG_SLICE_IN[0].clk == st_q.clk_prev[0] && REG_SLICE_IN[0].lsr &&
       st_q.mode[0] != tile_pkg::MODE_RAM) |=> $stable(st_q.q[0]);
   endproperty
   a_sync_hold: assert property (p_sync_hold) else $error("sync reset without edge");

   property p_carry;
      (st_q.mode[0] == tile_pkg::MODE_RIPPLE && st_q.mode[1] == tile_pkg::MODE_RIPPLE &&
       st_q.mode[2] == tile_pkg::MODE_RIPPLE && (in0[0][0] ^ in0[0][1]) &&
       (in1[0][0] ^ in1[0][1]) && (in0[1][0] ^ in0[1][1]) && (in1[1][0] ^ in1[1][1]) &&
       (in0[2][0] ^ in0[2][1]) && (in1[2][0] ^ in1[2][1])) |-> CARRY_OUT == CARRY_IN;
   endproperty
   a_carry: assert property (p_carry) else $error("carry chain broken");

   property p_ram;
      (CE_IN && st_q.mode[0] == tile_pkg::MODE_RAM && REG_SLICE_IN[0].ce &&
       REG_SLICE_IN[0].lsr == st_q.cfg[0].cs_pol)
      |=> st_q.lut[0][$past(in0[0])] == $past(m0[0]);
   endproperty
   a_ram: assert property (p_ram) else $error("RAM write lost");

   property p_status;
      (CE_IN && REG_RD_IN && REG_ADDR_IN == tile_pkg::ADDR_STATUS)
      |=> REG_RDATA_OUT[5:0] == $past(st_q.q) ##1 REG_RDATA_OUT == 32'h00000000 || $past(REG_RD_IN);
   endproperty
   a_status: assert property (p_status) else $error("status read wrong");

   c_carry: cover property (st_q.mode[2] == tile_pkg::MODE_RIPPLE && CARRY_OUT);
   c_ram: cover property (st_q.mode[0] == tile_pkg::MODE_RAM && REG_SLICE_IN[0].ce);
   c_wide8: cover property (m1[3] && ofx1[3]);
   c_async: cover property (REG_SLICE_IN[0].lsr && !st_q.cfg[0].sync_lsr);
endmodule

// >>> inc/tile_pkg.sv
// Constants, field layouts and carriers for the four-slice logic tile.
// Assumes a single core clock; routing signals arrive synchronous to it.
package tile_pkg;
   // Tile shape
   localparam int NUM_SLICES = 4;
   localparam int REG_SLICES = 3;
   localparam int NUM_LUTS = 8;
   localparam int LUT_BITS = 16;

   // Register port
   localparam int ADDR_W = 4;
   localparam int DATA_W = 32;
   localparam logic [3:0] ADDR_MODE = 4'h8;
   localparam logic [3:0] ADDR_REGCFG = 4'h9;
   localparam logic [3:0] ADDR_STATUS = 4'hA;

   // Field layout
   localparam int MODE_STRIDE = 2;
   localparam int CFG_STRIDE = 8;
   localparam int CFG_W = 6;
   localparam int STAT_Q = 0;
   localparam int STAT_VARIANT = 8;

   // Slice operating modes
   typedef enum logic [1:0] {MODE_LOGIC, MODE_RIPPLE, MODE_RAM, MODE_ROM} slice_mode_t;

   // Per-slice storage register configuration
   typedef struct packed {
      logic cs_pol;    // Chip-select level that enables RAM writes
      logic free_clk;  // 1: load every core cycle, 0: routed clock
      logic set_val;   // Value forced by set/reset
      logic sync_lsr;  // 1: set/reset waits for a clock event
      logic pos;       // 1: rising edge / high transparent
      logic edge_trig; // 1: edge triggered, 0: latch
   } reg_cfg_t;

   // Values after reset
   localparam logic [15:0] LUT_RESET = 16'h0000;
   localparam slice_mode_t MODE_RESET = MODE_LOGIC;
   localparam reg_cfg_t CFG_RESET = 6'h03;

   // Routing inputs of a slice with registers: 13 signals
   typedef struct packed {
      logic [3:0] lut1;
      logic [3:0] lut0;
      logic m1;
      logic m0;
      logic ce;
      logic clk;
      logic lsr;
   } reg_slice_in_t;

   // Routing inputs of the table-only slice: 10 signals
   typedef struct packed {
      logic [3:0] lut1;
      logic [3:0] lut0;
      logic m1;
      logic m0;
   } lut_slice_in_t;

   // Routing outputs of a slice with registers: 6 signals
   typedef struct packed {
      logic f0;
      logic f1;
      logic q0;
      logic q1;
      logic ofx0;
      logic ofx1;
   } reg_slice_out_t;

   // Routing outputs of the table-only slice: 4 signals
   typedef struct packed {
      logic f0;
      logic f1;
      logic ofx0;
      logic ofx1;
   } lut_slice_out_t;
endpackage

// >>> tb/routing_fabric.sv
// Routing fabric model: slice inputs, routed slice clocks, incoming carry.
// Assumes the bench changes requests just after a rising core clock edge.
`timescale 1ns/10ps
module routing_fabric (
   input wire logic clk_in,
   input wire tile_pkg::reg_slice_in_t [2:0] req_reg_in,
   input wire tile_pkg::lut_slice_in_t req_lut_in,
   input wire logic req_carry_in,
   input wire logic [2:0] clk_run_in,
   output tile_pkg::reg_slice_in_t [2:0] reg_slice_out,
   output tile_pkg::lut_slice_in_t lut_slice_out,
   output logic carry_out
);
   logic [2:0] rclk_q = 3'h0;

   // Routed clocks toggle once per core cycle only while enabled
   always_ff @(posedge clk_in)
   begin
      rclk_q <= rclk_q ^ clk_run_in;
   end

   // Requested levels with the routed clocks merged in
   always_comb
   begin
      reg_slice_out = req_reg_in;
      for (int s = 0; s < 3; s++)
      begin
         reg_slice_out[s].clk = rclk_q[s];
      end
   end
   assign lut_slice_out = req_lut_in;
   assign carry_out = req_carry_in;
endmodule

// >>> tb/configurable_logic_slice_tb_top.sv
// Bench for the logic tile: tables, modes, RAM, ripple, slice registers.
// Assumes the routing fabric model; both tile variants share the stimulus.
`timescale 1ns/10ps
module configurable_logic_slice_tb_top;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic [3:0] addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic wr_stb = 1'b0;
   logic rd_stb = 1'b0;
   logic [31:0] rdata;
   logic [31:0] rdata_rom;
   tile_pkg::reg_slice_in_t [2:0] req_reg = '0;
   tile_pkg::lut_slice_in_t req_lut = '0;
   logic req_carry = 1'b0;
   logic [2:0] clk_run = 3'h0;
   tile_pkg::reg_slice_in_t [2:0] reg_in;
   tile_pkg::lut_slice_in_t lut_in;
   logic carry_in;
   tile_pkg::reg_slice_out_t [2:0] reg_out;
   tile_pkg::lut_slice_out_t lut_out;
   logic carry_out;
   logic [7:0] got;
   int fail_count = 0;
   int samples_checked = 0;

   // Core clock, 8 ns period
   always #4 clk = ~clk;

   // Far side and both tile variants
   routing_fabric fabric (.clk_in(clk), .req_reg_in(req_reg), .req_lut_in(req_lut),
      .req_carry_in(req_carry), .clk_run_in(clk_run), .reg_slice_out(reg_in),
      .lut_slice_out(lut_in), .carry_out(carry_in));
   logic_tile #(.MEM_CAPABLE(1'b1)) uut (.CLOCK_IN(clk), .RST_IN(rst), .CE_IN(1'b1),
      .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr_stb), .REG_RD_IN(rd_stb),
      .REG_RDATA_OUT(rdata), .REG_SLICE_IN(reg_in), .LUT_SLICE_IN(lut_in),
      .CARRY_IN(carry_in), .REG_SLICE_OUT(reg_out), .LUT_SLICE_OUT(lut_out),
      .CARRY_OUT(carry_out));
   logic_tile #(.MEM_CAPABLE(1'b0)) uut_rom (.CLOCK_IN(clk), .RST_IN(rst), .CE_IN(1'b1),
      .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .REG_WR_IN(wr_stb), .REG_RD_IN(rd_stb),
      .REG_RDATA_OUT(rdata_rom), .REG_SLICE_IN(reg_in), .LUT_SLICE_IN(lut_in),
      .CARRY_IN(carry_in), .REG_SLICE_OUT(), .LUT_SLICE_OUT(), .CARRY_OUT());

   // Verdict and end of run
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // Compare and count
   task automatic chk(input logic [31:0] got_v, input logic [31:0] exp_v);
      samples_checked++;
      if (got_v !== exp_v)
      begin
         fail_count++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got_v, exp_v);
      end
   endtask

   // One-cycle write strobe
   task automatic reg_write(input logic [3:0] a, input logic [31:0] d);
      @(posedge clk);
      wr_stb <= 1'b1;
      addr <= a;
      wdata <= d;
      @(posedge clk);
      wr_stb <= 1'b0;
   endtask

   // One-cycle read strobe, data checked in the following cycle
   task automatic reg_read(input logic [3:0] a, input logic [31:0] exp_v);
      @(posedge clk);
      rd_stb <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd_stb <= 1'b0;
      #1;
      chk(rdata, exp_v);
   endtask

   // Single toggle of a routed slice clock
   task automatic pulse(input int s);
      @(posedge clk);
      clk_run[s] <= 1'b1;
      @(posedge clk);
      clk_run[s] <= 1'b0;
   endtask

   // Bounded wait for a slice's register pair {q0,q1}
   task automatic wait_q(input int s, input logic [1:0] e);
      int n;
      n = 0;
      while ({reg_out[s].q0, reg_out[s].q1} !== e && n < 4)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      chk({30'h0, reg_out[s].q0, reg_out[s].q1}, {30'h0, e});
      if ({reg_out[s].q0, reg_out[s].q1} !== e)
         final_report();
   endtask

   // {f0,f1,ofx0} of all four slices
   task automatic check_slices(input logic [2:0] e);
      @(negedge clk);
      for (int s = 0; s < 3; s++)
         chk({29'h0, reg_out[s].f0, reg_out[s].f1, reg_out[s].ofx0}, {29'h0, e});
      chk({29'h0, lut_out.f0, lut_out.f1, lut_out.ofx0}, {29'h0, e});
   endtask

   // Expected sums and carry of the six-bit ripple chain
   function automatic logic [7:0] ripple_exp(input tile_pkg::reg_slice_in_t [2:0] v,
      input logic c);
      logic [7:0] r;
      logic [3:0] ab;
      r = 8'h00;
      for (int k = 0; k < 6; k++)
      begin
         ab = (k % 2 == 0) ? v[k / 2].lut0 : v[k / 2].lut1;
         r[k] = ab[0] ^ ab[1] ^ c;
         c = (ab[0] & ab[1]) | (c & (ab[0] ^ ab[1]));
      end
      r[6] = c;
      return r;
   endfunction

   // Main sequence
   initial
   begin
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      chk(32'($bits(reg_in) + $bits(lut_in) + 1), 32'h32);
      chk(32'($bits(reg_out) + $bits(lut_out) + 1), 32'h17);
      chk(32'($bits(tile_pkg::reg_slice_in_t) + 1), 32'hE);
      chk(32'($bits(tile_pkg::reg_slice_out_t) + 1), 32'h7);
      chk(32'($bits(lut_in) + $bits(lut_out)), 32'hE);
      for (int n = 0; n < 8; n++)
         reg_read(4'(n), 32'h0);
      reg_read(tile_pkg::ADDR_REGCFG, 32'h30303);
      reg_read(tile_pkg::ADDR_STATUS, 32'h100);
      chk(rdata_rom, 32'h0);
      reg_write(4'hB, 32'hFFFF);
      reg_read(4'hB, 32'h0);
      reg_write(tile_pkg::ADDR_MODE, 32'hAA);
      reg_read(tile_pkg::ADDR_MODE, 32'h2A);
      chk(rdata_rom, 32'h0);
      reg_write(tile_pkg::ADDR_MODE, 32'h7F);
      reg_read(tile_pkg::ADDR_MODE, 32'h3F);
      reg_write(tile_pkg::ADDR_MODE, 32'h0);
      // One-hot tables, then wide-function select
      for (int n = 0; n < 8; n++)
         reg_write(4'(n), 32'h1 << n);
      @(posedge clk);
      for (int s = 0; s < 3; s++)
      begin
         req_reg[s].ce <= 1'b1;
         req_reg[s].lut0 <= 4'(2 * s);
         req_reg[s].lut1 <= 4'(2 * s + 1);
      end
      req_lut.lut0 <= 4'h6;
      req_lut.lut1 <= 4'h7;
      check_slices(3'b111);
      @(posedge clk);
      for (int s = 0; s < 3; s++)
      begin
         req_reg[s].lut1 <= 4'(2 * s);
         req_reg[s].m0 <= 1'b1;
      end
      req_lut.lut1 <= 4'h6;
      req_lut.m0 <= 1'b1;
      check_slices(3'b100);
      // Six-, seven- and eight-input selects
      @(posedge clk);
      req_reg[1].m0 <= 1'b0;
      req_reg[0].m1 <= 1'b1;
      req_reg[1].m1 <= 1'b1;
      req_lut.lut1 <= 4'hE;
      req_lut.m1 <= 1'b1;
      @(negedge clk);
      chk({27'h0, reg_out[1].ofx0, reg_out[0].ofx1, reg_out[1].ofx1, reg_out[2].ofx1,
         lut_out.ofx1}, 32'h19);
      // Fabric write into slice 0 tables while in RAM mode
      @(posedge clk);
      req_reg[0].lut0 <= 4'h5;
      req_reg[0].m1 <= 1'b1;
      reg_write(tile_pkg::ADDR_MODE, 32'h2);
      reg_write(tile_pkg::ADDR_MODE, 32'h0);
      reg_read(4'h0, 32'h21);
      chk(rdata_rom, 32'h1);
      reg_read(4'h1, 32'h22);
      // Ripple adds through slices 0 to 2, both carry inputs
      reg_write(tile_pkg::ADDR_MODE, 32'hD5);
      for (int s = 0; s < 3; s++)
      begin
         req_reg[s].lut0 <= 4'h3;
         req_reg[s].lut1 <= 4'(s);
      end
      for (int c = 0; c < 4; c++)
      begin
         @(posedge clk);
         req_carry <= c[0];
         // Last two passes propagate along the whole chain
         if (c == 2)
         begin
            for (int s = 0; s < 3; s++)
            begin
               req_reg[s].lut0 <= 4'h1;
               req_reg[s].lut1 <= 4'h2;
            end
         end
         @(negedge clk);
         for (int s = 0; s < 3; s++)
            got[2 * s +: 2] = {reg_out[s].f1, reg_out[s].f0};
         got[7:6] = {1'b0, carry_out};
         chk({24'h0, got}, {24'h0, ripple_exp(req_reg, c[0])});
      end
      // Slice 0 register edges, rising then falling configuration
      reg_write(tile_pkg::ADDR_MODE, 32'h0);
      reg_write(4'h0, 32'hFFFF);
      reg_write(4'h1, 32'h0);
      pulse(0);
      wait_q(0, 2'b10);
      reg_read(tile_pkg::ADDR_STATUS, 32'h101);
      reg_write(4'h0, 32'h0);
      pulse(0);
      repeat (4) @(posedge clk);
      wait_q(0, 2'b10);
      reg_write(tile_pkg::ADDR_REGCFG, 32'h30301);
      pulse(0);
      repeat (4) @(posedge clk);
      wait_q(0, 2'b10);
      pulse(0);
      wait_q(0, 2'b00);
      // Async set, sync reset waiting for an event, slice 1 on core clock, slice 2 latch shut
      reg_write(tile_pkg::ADDR_REGCFG, 32'h2000B);
      req_reg[0].lsr <= 1'b1;
      wait_q(0, 2'b11);
      reg_write(4'h2, 32'hFFFF);
      reg_write(4'h3, 32'hFFFF);
      reg_write(tile_pkg::ADDR_REGCFG, 32'h31307);
      repeat (4) @(posedge clk);
      wait_q(0, 2'b11);
      wait_q(1, 2'b11);
      pulse(0);
      wait_q(0, 2'b00);
      wait_q(2, 2'b00);
      final_report();
   end
endmodule
